//--- rtl/tsm_pkg.sv
package tsm_pkg;
// Overview of operation
// - Stay silent for a five second start-up interval after reset.
// - Stop mode: send one model and version banner, then nothing unsolicited.
// - Run mode: send measurement messages at once, no host command needed.
// - Polled mode: send nothing after start-up until properly addressed.
// - Modbus mode: send nothing after start-up on its own.
// - Both ends run the line at 19200 baud by default; tsm_host_model instead defaults to DIV 8 clocks per bit.
// - Frames carry 8 data bits, no parity, 1 stop bit.
// - Each device on a shared line has a unique address 0 to 255.
// - Polled mode still answers the double question mark request.

   localparam int unsigned CLK_HZ      = 40_000_000;
   localparam int unsigned STARTUP_S   = 5;
   localparam int unsigned STARTUP_CYC = STARTUP_S * CLK_HZ;
   localparam int unsigned BAUD        = 19200;
   localparam int unsigned BAUD_DIV    = CLK_HZ / BAUD;
   localparam int unsigned DATA_BITS   = 8;
   localparam int unsigned FRAME_BITS  = DATA_BITS + 2;
   localparam int unsigned CNT_W       = 16;

   localparam int unsigned ADDR_W   = 5;
   localparam logic [4:0]  OFS_CTRL = 5'h00;
   localparam logic [4:0]  OFS_STAT = 5'h04;
   localparam logic [4:0]  OFS_TXD  = 5'h08;
   localparam logic [4:0]  OFS_RXD  = 5'h0c;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   localparam int unsigned STAT_INFO   = 4;

   localparam logic [1:0] MODE_STOP   = 2'h0;
   localparam logic [1:0] MODE_RUN    = 2'h1;
   localparam logic [1:0] MODE_POLL   = 2'h2;
   localparam logic [1:0] MODE_MODBUS = 2'h3;
   localparam logic [7:0] QMARK       = 8'h3f;

   // Banner text is an arbitrary neutral value
   localparam int unsigned BANNER_LEN = 12;
   localparam logic [8*BANNER_LEN-1:0] BANNER = "XMTR 1.0.0\r\n";
   localparam logic [3:0] BAN_LAST = 4'(BANNER_LEN - 1);

   typedef struct packed {
      logic [7:0] addr;
      logic       open;
      logic [1:0] mode;
   } tsm_ctrl_t;
   localparam tsm_ctrl_t CTRL_RST = '{addr: 8'h00, open: 1'b0,
                                      mode: MODE_STOP};

   typedef struct packed {
      logic [1:0] mode;
      logic       rx_seen;
      logic       banner_done;
      logic       info_req;
      logic       rx_valid;
      logic       tx_full;
      logic       tx_busy;
      logic       started;
   } tsm_stat_t;

   typedef enum logic [1:0] {PH_WAIT, PH_BANNER, PH_RUN} tsm_phase_t;

   function automatic logic [7:0] tsm_banner_byte(input logic [3:0] i);
      return BANNER[8*(BANNER_LEN-1-32'(i)) +: 8];
   endfunction : tsm_banner_byte

   function automatic logic tsm_mapped(input logic [ADDR_W-1:0] a);
      return a == OFS_CTRL || a == OFS_STAT || a == OFS_TXD ||
             a == OFS_RXD;
   endfunction : tsm_mapped
endpackage : tsm_pkg

//--- rtl/tsm_uart.sv
`timescale 1ns/10ps
module tsm_uart import tsm_pkg::*; #(
   parameter int unsigned DIV = BAUD_DIV
) (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic                 tx_start,
   input  wire logic [DATA_BITS-1:0] tx_data,
   output logic                      tx_o,
   output logic                      de_o,
   input  wire logic                 rx_i,
   output logic                      rx_valid,
   output logic [DATA_BITS-1:0]      rx_byte
);
   localparam logic [CNT_W-1:0] DIV_M1 = CNT_W'(DIV - 1);
   localparam logic [CNT_W-1:0] HALF   = CNT_W'(DIV / 2);
   localparam logic [3:0]       LAST   = 4'(FRAME_BITS - 1);

   logic [DATA_BITS:0]   sh_q;
   logic [3:0]           bit_q;
   logic [CNT_W-1:0]     bc_q;
   logic                 ract_q;
   logic [3:0]           rbit_q;
   logic [CNT_W-1:0]     rbc_q;
   logic [DATA_BITS-1:0] rsh_q;

   ////////////////////////////////////////////////////////////////////////
   // Transmit, 8N1; de_o doubles as the busy flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         de_o  <= 1'b0;
         tx_o  <= 1'b1;
         sh_q  <= '0;
         bit_q <= '0;
         bc_q  <= '0;
      end else if (!de_o) begin
         if (tx_start) begin
            de_o  <= 1'b1;
            tx_o  <= 1'b0;
            sh_q  <= {1'b1, tx_data};
            bit_q <= '0;
            bc_q  <= '0;
         end
      end else if (bc_q == DIV_M1) begin
         bc_q <= '0;
         if (bit_q == LAST) begin
            de_o <= 1'b0;
            tx_o <= 1'b1;
         end else begin
            tx_o  <= sh_q[0];
            sh_q  <= {1'b1, sh_q[DATA_BITS:1]};
            bit_q <= bit_q + 4'h1;
         end
      end else begin
         bc_q <= bc_q + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive, sampled mid-bit; a false start bit is dropped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ract_q   <= 1'b0;
         rbit_q   <= '0;
         rbc_q    <= '0;
         rsh_q    <= '0;
         rx_valid <= 1'b0;
         rx_byte  <= '0;
      end else begin
         rx_valid <= 1'b0;
         if (!ract_q) begin
            if (!rx_i) begin
               ract_q <= 1'b1;
               rbc_q  <= HALF;
               rbit_q <= '0;
            end
         end else if (rbc_q != '0) begin
            rbc_q <= rbc_q - 16'h0001;
         end else begin
            rbc_q  <= DIV_M1;
            rbit_q <= rbit_q + 4'h1;
            if (rbit_q == '0) begin
               if (rx_i) ract_q <= 1'b0;
            end else if (rbit_q == LAST) begin
               ract_q <= 1'b0;
               if (rx_i) begin
                  rx_valid <= 1'b1;
                  rx_byte  <= rsh_q;
               end
            end else begin
               rsh_q <= {rx_i, rsh_q[DATA_BITS-1:1]};
            end
         end
      end
   end
endmodule : tsm_uart

//--- rtl/tsm_top.sv
`timescale 1ns/10ps
module tsm_top import tsm_pkg::*; #(
   parameter int unsigned STARTUP_CYCLES = STARTUP_CYC,
   parameter int unsigned DIV            = BAUD_DIV
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   output logic                   tx_o,
   output logic                   de_o,
   input  wire logic              rx_i
);
   localparam int unsigned FRAME_CYC = FRAME_BITS * DIV;

   logic [31:0]       boot_cnt_q;
   tsm_phase_t        ph_q;
   logic [3:0]        ban_idx_q;
   logic              bandone_q;
   logic [1:0]        mode_q;
   tsm_ctrl_t         ctrl_q;
   logic              txfull_q;
   logic [7:0]        txbyte_q;
   logic              rxv_q;
   logic [7:0]        rxd_q;
   logic              rxseen_q;
   logic              qm_q;
   logic              info_q;
   logic              aw_held_q, w_held_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              aw_hold_d, w_hold_d, rvalid_d;
   logic              wr_go, ar_take, ban_go, sw_go, sw_ok;
   logic              tx_start, rx_pulse, info_set;
   logic [7:0]        tx_data, rx_byte;
   tsm_stat_t         stat;
   logic [31:0]       de_len_q;

   tsm_uart #(.DIV(DIV)) u_uart (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .tx_start (tx_start),
      .tx_data  (tx_data),
      .tx_o     (tx_o),
      .de_o     (de_o),
      .rx_i     (rx_i),
      .rx_valid (rx_pulse),
      .rx_byte  (rx_byte)
   );

   ////////////////////////////////////////////////////////////////////////
   // Start-up timing and mode latch
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         boot_cnt_q <= '0;
         ph_q       <= PH_WAIT;
         mode_q     <= MODE_STOP;
         ban_idx_q  <= '0;
         bandone_q  <= 1'b0;
      end else begin
         unique case (ph_q)
            PH_WAIT: begin
               boot_cnt_q <= boot_cnt_q + 32'h1;
               if (boot_cnt_q == STARTUP_CYCLES - 1) begin
                  // Mode changes after this point wait for a reset
                  mode_q <= ctrl_q.mode;
                  ph_q   <= (ctrl_q.mode == MODE_STOP) ? PH_BANNER
                                                       : PH_RUN;
               end
            end
            PH_BANNER: if (ban_go) begin
               ban_idx_q <= ban_idx_q + 4'h1;
               if (ban_idx_q == BAN_LAST) begin
                  bandone_q <= 1'b1;
                  ph_q      <= PH_RUN;
               end
            end
            PH_RUN: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit gating per mode
   always_comb begin
      unique case (mode_q)
         MODE_RUN:  sw_ok = 1'b1;
         MODE_POLL: sw_ok = ctrl_q.open | info_q;
         default:   sw_ok = rxseen_q;
      endcase
   end
   assign ban_go   = (ph_q == PH_BANNER) && !de_o;
   assign sw_go    = (ph_q == PH_RUN) && txfull_q && sw_ok && !de_o;
   assign tx_start = ban_go | sw_go;
   assign tx_data  = ban_go ? tsm_banner_byte(ban_idx_q) : txbyte_q;
   assign info_set = rx_pulse && rx_byte == QMARK && qm_q &&
                     mode_q == MODE_POLL && ph_q != PH_WAIT;

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite handshakes, one write and one read in flight
   assign wr_go     = aw_held_q && w_held_q && !bvalid;
   assign ar_take   = arvalid && arready;
   assign aw_hold_d = (aw_held_q && !wr_go) || (awvalid && awready);
   assign w_hold_d  = (w_held_q && !wr_go) || (wvalid && wready);
   assign rvalid_d  = ar_take || (rvalid && !rready);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         awready   <= 1'b0;
         wready    <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
         bvalid    <= 1'b0;
         bresp     <= RESP_OKAY;
      end else begin
         aw_held_q <= aw_hold_d;
         w_held_q  <= w_hold_d;
         awready   <= !aw_hold_d;
         wready    <= !w_hold_d;
         if (awvalid && awready) awaddr_q <= awaddr;
         if (wvalid && wready) begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (wr_go) begin
            bvalid <= 1'b1;
            bresp  <= tsm_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   assign stat = '{mode: mode_q, rx_seen: rxseen_q,
                   banner_done: bandone_q, info_req: info_q,
                   rx_valid: rxv_q, tx_full: txfull_q, tx_busy: de_o,
                   started: ph_q != PH_WAIT};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= RESP_OKAY;
      end else begin
         arready <= !rvalid_d;
         rvalid  <= rvalid_d;
         if (ar_take) begin
            rresp <= tsm_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (araddr)
               OFS_CTRL: rdata <= 32'(ctrl_q);
               OFS_STAT: rdata <= 32'(stat);
               OFS_TXD:  rdata <= 32'(txbyte_q);
               OFS_RXD:  rdata <= 32'(rxd_q);
               default:  rdata <= '0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register effects
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= CTRL_RST;
      end else if (wr_go && awaddr_q == OFS_CTRL) begin
         if (wstrb_q[0]) begin
            ctrl_q.mode <= wdata_q[1:0];
            ctrl_q.open <= wdata_q[2];
            ctrl_q.addr[4:0] <= wdata_q[7:3];
         end
         if (wstrb_q[1]) ctrl_q.addr[7:5] <= wdata_q[10:8];
      end
   end

   // A byte written while one is pending is dropped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         txfull_q <= 1'b0;
         txbyte_q <= '0;
      end else if (sw_go) begin
         txfull_q <= 1'b0;
      end else if (wr_go && awaddr_q == OFS_TXD && wstrb_q[0] &&
                   !txfull_q) begin
         txfull_q <= 1'b1;
         txbyte_q <= wdata_q[7:0];
      end
   end

   // Hardware set wins over software clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rxv_q    <= 1'b0;
         rxd_q    <= '0;
         rxseen_q <= 1'b0;
         qm_q     <= 1'b0;
         info_q   <= 1'b0;
      end else begin
         if (rx_pulse) begin
            rxv_q    <= 1'b1;
            rxd_q    <= rx_byte;
            rxseen_q <= ph_q != PH_WAIT;
            qm_q     <= rx_byte == QMARK;
         end else if (ar_take && araddr == OFS_RXD) begin
            rxv_q <= 1'b0;
         end
         if (info_set) begin
            info_q <= 1'b1;
         end else if (wr_go && awaddr_q == OFS_STAT && wstrb_q[0] &&
                      wdata_q[STAT_INFO]) begin
            info_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   always_ff @(posedge aclk) begin
      if (!aresetn) de_len_q <= '0;
      else          de_len_q <= de_o ? de_len_q + 32'h1 : '0;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_boot_quiet;
      ph_q == PH_WAIT |-> !de_o && tx_o;
   endproperty
   a_boot_quiet: assert property (p_boot_quiet)
      else $error("line active during start-up");
   property p_boot_len;
      ph_q != PH_WAIT && $past(ph_q) == PH_WAIT |->
         $past(boot_cnt_q) == STARTUP_CYCLES - 1;
   endproperty
   a_boot_len: assert property (p_boot_len)
      else $error("start-up interval wrong length");
   property p_banner_once;
      bandone_q && mode_q == MODE_STOP && !rxseen_q |-> !tx_start;
   endproperty
   a_banner_once: assert property (p_banner_once)
      else $error("unsolicited byte after banner");
   property p_banner_len;
      $rose(bandone_q) |-> $past(ban_idx_q) == BAN_LAST &&
                           mode_q == MODE_STOP;
   endproperty
   a_banner_len: assert property (p_banner_len)
      else $error("banner length wrong");
   property p_run_now;
      ph_q == PH_RUN && mode_q == MODE_RUN && txfull_q && !de_o |->
         tx_start ##1 de_o;
   endproperty
   a_run_now: assert property (p_run_now)
      else $error("run mode output delayed");
   property p_poll_quiet;
      mode_q == MODE_POLL && !ctrl_q.open && !info_q |-> !tx_start;
   endproperty
   a_poll_quiet: assert property (p_poll_quiet)
      else $error("unaddressed poll output");
   property p_mbus_quiet;
      mode_q == MODE_MODBUS && !rxseen_q |-> !tx_start;
   endproperty
   a_mbus_quiet: assert property (p_mbus_quiet)
      else $error("modbus output without request");
   property p_frame_len;
      $fell(de_o) |-> de_len_q == FRAME_CYC && $past(tx_o);
   endproperty
   a_frame_len: assert property (p_frame_len)
      else $error("frame length wrong");
   property p_info;
      info_set |=> info_q;
   endproperty
   a_info: assert property (p_info)
      else $error("info request lost");
   property p_driver;
      (!de_o |-> tx_o) and (tx_start |=> de_o);
   endproperty
   a_driver: assert property (p_driver)
      else $error("driver enable mismatch");

   c_banner: cover property ($rose(bandone_q));
   c_run:    cover property (sw_go && mode_q == MODE_RUN);
   c_info:   cover property ($rose(info_q));
   c_rx:     cover property (rx_pulse && rxseen_q);
endmodule : tsm_top

//--- dv/tsm_host_model.sv
`timescale 1ns/10ps
module tsm_host_model import tsm_pkg::*; #(
   parameter int unsigned DIV = 8
) (
   input  wire logic aclk,
   input  wire logic txd_line,
   input  wire logic drv_en,
   output logic      rxd_line
);
   logic [7:0] got[$];
   int         errs;
   int         de_len;

   initial begin
      rxd_line = 1'b1;
      errs     = 0;
      de_len   = 0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Mid-bit sampling, LSB first, stop bit must be high
   always begin : rx_frames
      logic [7:0] b;
      @(posedge aclk);
      while (!(drv_en === 1'b1 && txd_line === 1'b0)) @(posedge aclk);
      repeat (DIV / 2) @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
         repeat (DIV) @(posedge aclk);
         b[i] = txd_line;
      end
      repeat (DIV) @(posedge aclk);
      if (txd_line !== 1'b1) errs++;
      got.push_back(b);
      @(posedge aclk);
      while (drv_en === 1'b1) @(posedge aclk);
   end

   // Driver enable must span exactly one frame
   always @(posedge aclk) begin
      if (drv_en === 1'b1) begin
         de_len <= de_len + 1;
      end else begin
         if (de_len != 0 && de_len != 10 * DIV) errs++;
         de_len <= 0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // No handshake lines at all, plain 8N1
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      // Half duplex: never talk over the device
      for (int n = 0; n < 5000 && drv_en === 1'b1; n++) begin
         @(posedge aclk);
      end
      // A device that never goes quiet is a failure, not a wait
      if (drv_en === 1'b1) errs++;
      @(posedge aclk);
      for (int i = 0; i < 10; i++) begin
         rxd_line <= f[i];
         repeat (DIV) @(posedge aclk);
      end
      rxd_line <= 1'b1;
   endtask : send_byte
endmodule : tsm_host_model

//--- dv/testbench.sv
`timescale 1ns/10ps
module testbench import tsm_pkg::*;;
   localparam int unsigned STUP = 50;
   localparam int unsigned DV   = 8;

   logic              aclk, aresetn, awvalid, wvalid, bready;
   logic              arvalid, rready, rx_line, tx_line, drv_en;
   logic              awready, wready, bvalid, arready, rvalid;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0]       wdata, rdata;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp;
   int                miscompares, checks, cyc;

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   always @(posedge aclk) cyc <= aresetn ? cyc + 1 : 0;

   tsm_top #(.STARTUP_CYCLES(STUP), .DIV(DV)) i_dut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .tx_o(tx_line), .de_o(drv_en), .rx_i(rx_line));

   tsm_host_model #(.DIV(DV)) i_host (.aclk(aclk), .txd_line(tx_line),
      .drv_en(drv_en), .rxd_line(rx_line));

   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      if (miscompares == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] seen);
      checks++;
      if (seen !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
         miscompares++;
      end
   endtask : chk

   task automatic hang(input string nm);
      chk(nm, 1, 0);
      print_verdict();
   endtask : hang

   // Fresh edge first: never re-drive a strobe in one time step
   task automatic wr(input logic [4:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      int n;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awready && awvalid) awvalid <= 1'b0;
         if (wready && wvalid) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      if (n == 50) hang("bvalid");
      bready <= 1'b0;
      chk("bresp", er, bresp);
   endtask : wr

   task automatic rd(input logic [4:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      int n;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arready && arvalid) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      if (n == 50) hang("rvalid");
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd

   // Idle gap before a mid-run reset; the first reset starts at once
   task automatic do_reset;
      if (aresetn === 1'b1) begin
         repeat (DV) @(posedge aclk);
      end
      aresetn <= 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      i_host.got.delete();
   endtask : do_reset

   task automatic wait_bytes(input int n, input string nm);
      for (int k = 0; k < 20000 && i_host.got.size() < n; k++) begin
         @(posedge aclk);
      end
      if (i_host.got.size() < n) hang(nm);
      chk(nm, n, i_host.got.size());
   endtask : wait_bytes

   task automatic first_tx(output int t);
      int k;
      for (k = 0; k < 2000 && drv_en !== 1'b1; k++) @(posedge aclk);
      if (k == 2000) hang("first_frame");
      t = cyc;
   endtask : first_tx

   ////////////////////////////////////////////////////////////////////////
   task automatic t_stop;
      int          t;
      logic [31:0] d;
      logic [1:0]  r;
      do_reset();
      first_tx(t);
      chk("startup_gap", 1, t >= STUP && t <= STUP + 16);
      wait_bytes(BANNER_LEN, "banner_len");
      for (int k = 0; k < BANNER_LEN; k++) begin
         chk("banner", BANNER[8*(BANNER_LEN-1-k) +: 8], i_host.got[k]);
      end
      wr(OFS_TXD, 32'h55, RESP_OKAY);
      repeat (30 * DV) @(posedge aclk);
      chk("stop_quiet", BANNER_LEN, i_host.got.size());
      // A received byte solicits the pending one
      i_host.send_byte(8'h0d);
      wait_bytes(BANNER_LEN + 1, "stop_reply");
      chk("stop_reply_byte", 32'h55, i_host.got[BANNER_LEN]);
      rd(OFS_STAT, d, r);
      chk("stat_stop", 32'h21, d & 32'h1a1);
      chk("rresp_okay", RESP_OKAY, r);
   endtask : t_stop

   task automatic t_run;
      int          t;
      logic [31:0] d;
      logic [1:0]  r;
      do_reset();
      wr(OFS_CTRL, {30'h0, MODE_RUN}, RESP_OKAY);
      wr(OFS_TXD, 32'h5a, RESP_OKAY);
      first_tx(t);
      chk("run_gap", 1, t >= STUP);
      wait_bytes(1, "run_len");
      chk("run_byte", 32'h5a, i_host.got[0]);
      wr(OFS_TXD, 32'ha5, RESP_OKAY);
      wait_bytes(2, "run_len2");
      chk("run_byte2", 32'ha5, i_host.got[1]);
      i_host.send_byte(8'hc3);
      repeat (DV) @(posedge aclk);
      rd(OFS_RXD, d, r);
      chk("rx_byte", 32'hc3, d & 32'hff);
   endtask : t_run

   task automatic t_poll;
      logic [31:0] d;
      logic [1:0]  r;
      do_reset();
      wr(OFS_CTRL, {30'h0, MODE_POLL}, RESP_OKAY);
      repeat (STUP + 10) @(posedge aclk);
      wr(OFS_TXD, 32'h11, RESP_OKAY);
      repeat (30 * DV) @(posedge aclk);
      chk("poll_quiet", 0, i_host.got.size());
      i_host.send_byte(QMARK);
      i_host.send_byte(QMARK);
      repeat (DV) @(posedge aclk);
      rd(OFS_STAT, d, r);
      chk("info_req", 1, d[STAT_INFO]);
      wait_bytes(1, "info_len");
      chk("info_byte", 32'h11, i_host.got[0]);
      rd(OFS_RXD, d, r);
      chk("rx_qmark", QMARK, d & 32'hff);
      wr(OFS_STAT, 32'h10, RESP_OKAY);
      rd(OFS_STAT, d, r);
      chk("info_clr", 0, d[STAT_INFO]);
      wr(OFS_TXD, 32'h22, RESP_OKAY);
      repeat (30 * DV) @(posedge aclk);
      chk("poll_quiet2", 1, i_host.got.size());
      // Highest address, addressed bit set
      wr(OFS_CTRL, 32'h7fe, RESP_OKAY);
      wait_bytes(2, "open_len");
      chk("open_byte", 32'h22, i_host.got[1]);
      rd(OFS_CTRL, d, r);
      chk("ctrl_back", 32'h7fe, d & 32'h7ff);
   endtask : t_poll

   task automatic t_modbus;
      logic [31:0] d;
      logic [1:0]  r;
      do_reset();
      wr(OFS_CTRL, {30'h0, MODE_MODBUS}, RESP_OKAY);
      repeat (STUP + 10) @(posedge aclk);
      wr(OFS_TXD, 32'h77, RESP_OKAY);
      repeat (30 * DV) @(posedge aclk);
      chk("modbus_quiet", 0, i_host.got.size());
      rd(OFS_STAT, d, r);
      chk("stat_mode", 32'h181, d & 32'h181);
      wr(5'h10, 32'h0, RESP_SLVERR);
      rd(5'h14, d, r);
      chk("rresp_unmapped", RESP_SLVERR, r);
   endtask : t_modbus

   ////////////////////////////////////////////////////////////////////////
   initial begin
      miscompares = 0;
      checks      = 0;
      cyc         = 0;
      aresetn     = 1'b0;
      awvalid     = 1'b0;
      wvalid      = 1'b0;
      bready      = 1'b0;
      arvalid     = 1'b0;
      rready      = 1'b0;
      awaddr      = '0;
      araddr      = '0;
      wdata       = '0;
      wstrb       = 4'h0;
      t_stop();
      t_run();
      t_poll();
      t_modbus();
      chk("host_frames", 0, i_host.errs);
      print_verdict();
   end
endmodule : testbench
